// ===== design/analog_sampler.sv
// Fixed-rate analog sample strobe and code capture
`timescale 1ns/10ps
module analog_sampler (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic [11:0] adc_code,
	output logic             adc_start,
	output logic [11:0]      sample,
	output logic             sample_new
);

	logic [15:0] div_r;
	logic [15:0] div_nxt;
	logic        start_r;
	logic        start_nxt;
	logic        new_r;
	logic        new_nxt;
	logic [11:0] sample_r;
	logic [11:0] sample_nxt;

	always_comb begin
		div_nxt    = div_r + 16'h0001;
		start_nxt  = 1'b0;
		new_nxt    = 1'b0;
		sample_nxt = sample_r;
		if (div_r == 16'(drive_mode_pkg::SAMPLE_CYC - 1)) begin
			div_nxt   = 16'h0000;
			start_nxt = 1'b1;
		end
		// Code is taken in the cycle the start strobe is high
		if (start_r) begin
			sample_nxt = adc_code;
			new_nxt    = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			div_r    <= 16'h0000;
			start_r  <= 1'b0;
			new_r    <= 1'b0;
			sample_r <= 12'h000;
		end else begin
			div_r    <= div_nxt;
			start_r  <= start_nxt;
			new_r    <= new_nxt;
			sample_r <= sample_nxt;
		end
	end

	assign adc_start  = start_r;
	assign sample     = sample_r;
	assign sample_new = new_r;

endmodule : analog_sampler

// ===== design/special_drive_mode_select.sv
// Special drive mode selection, setpoint generation and register slave
`timescale 1ns/10ps

// How it works
// - After good auto setup, request store of drive and tuning categories.
// - Special modes take setpoints from step/direction or analog inputs.
// - Digital input one is the drive enable in special modes.
// - In special modes power state follows enable only; controlword state requests ignored.
// - Special modes on after reset; off when activation bit is zero.
// - Four-bit switch selects mode; factory setting is one.
// - Switch bit three set means closed loop, clear means open loop.
// - Low values 0 and 1 select step-pulse and direction operation.
// - Low values 2 and 3 select test run, clockwise then counterclockwise.
// - Test run turns at 30 rpm while enable is high.
// - Analog even low value 1000 rpm full scale, odd 100 rpm.
// - Low 4,5 use direction input; low 6,7 use mid-scale joystick.
// - Switch is latched once after reset; later changes are ignored.
// - Analog modes run velocity mode and update target velocity.
// - Speed is scaled by velocity numerator over denominator.
// - Normal analog: linear, direction input sign, dead zone to 20 mV.
// - Joystick: zero within 20 mV of mid-scale, signed either side.
module special_drive_mode_select (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [3:0]  hex_switch,
	input  wire logic        enable_in,
	input  wire logic        step_in,
	input  wire logic        direction_in,
	input  wire logic [11:0] adc_code,
	input  wire logic        autosetup_ok,
	input  wire logic        store_ack,
	output logic             adc_start,
	output logic             velocity_mode,
	output logic             closed_loop,
	output logic             power_enabled,
	output logic [31:0]      target_velocity,
	output logic [31:0]      position_cmd,
	output logic             store_req,
	output logic [7:0]       store_categories
);

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Magnitude above the dead zone, or zero inside it
	function automatic logic [11:0] dead_zone(input logic [11:0] mag);
		if (mag <= 12'(drive_mode_pkg::DEAD_CODES))
			return 12'h000;
		return mag;
	endfunction : dead_zone

	// Linear map of a code magnitude onto full-scale rpm
	function automatic logic [31:0] to_rpm(input logic [11:0] mag,
			input logic [31:0] fs, input logic [31:0] span);
		logic [43:0] prod;
		prod = 44'(mag) * 44'(fs);
		return 32'(prod / 44'(span));
	endfunction : to_rpm

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic                        special_r, special_nxt;
	logic [15:0]                 ctrlword_r, ctrlword_nxt;
	logic [15:0]                 vel_num_r, vel_num_nxt;
	logic [15:0]                 vel_den_r, vel_den_nxt;
	logic                        wait_r, wait_nxt;
	logic [31:0]                 rdata_r, rdata_nxt;
	logic [3:0]                  switch_r, switch_nxt;
	logic                        latched_r, latched_nxt;
	drive_mode_pkg::drive_mode_t mode;
	drive_mode_pkg::power_state_t pwr_r, pwr_nxt;
	logic                        step_d_r, step_d_nxt;
	logic [31:0]                 pos_r, pos_nxt;
	logic [31:0]                 vel_r, vel_nxt;
	logic                        velmode_r, velmode_nxt;
	logic                        closed_r, closed_nxt;
	logic                        store_r, store_nxt;
	logic                        coord_bad_r, coord_bad_nxt;
	logic [11:0]                 sample;
	logic                        sample_new;
	logic [31:0]                 fs_rpm;
	logic [31:0]                 raw_rpm;
	logic                        negative;
	logic [11:0]                 mag;
	logic [47:0]                 scaled;
	logic [31:0]                 speed;
	logic                        wr_take;

	////////////////////////////////////////////////////////////////////////
	// Analog sampling

	analog_sampler u_sampler (
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.adc_code   (adc_code),
		.adc_start  (adc_start),
		.sample     (sample),
		.sample_new (sample_new)
	);

	////////////////////////////////////////////////////////////////////////
	// Register slave: one wait cycle, then the answer

	assign wr_take = avs_write && !wait_r;

	always_comb begin
		wait_nxt     = !((avs_read || avs_write) && wait_r);
		rdata_nxt    = rdata_r;
		special_nxt  = special_r;
		ctrlword_nxt = ctrlword_r;
		vel_num_nxt  = vel_num_r;
		vel_den_nxt  = vel_den_r;
		if (avs_read && wait_r) begin
			if (avs_address == drive_mode_pkg::OFS_CONTROL) begin
				rdata_nxt = {31'h0, special_r};
			end else if (avs_address == drive_mode_pkg::OFS_CTRLWORD) begin
				rdata_nxt = {16'h0, ctrlword_r};
			end else if (avs_address == drive_mode_pkg::OFS_STATUS) begin
				rdata_nxt = 32'h0;
				rdata_nxt[drive_mode_pkg::STAT_SWITCH_LSB +: 4] = switch_r;
				rdata_nxt[drive_mode_pkg::STAT_CLOSED_BIT]    = closed_r;
				rdata_nxt[drive_mode_pkg::STAT_ENABLED_BIT]   = pwr_r ==
					drive_mode_pkg::PWR_ENABLED;
				rdata_nxt[drive_mode_pkg::STAT_SPECIAL_BIT]   = special_r;
				rdata_nxt[drive_mode_pkg::STAT_COORD_BAD_BIT] = coord_bad_r;
				rdata_nxt[drive_mode_pkg::STAT_STORE_BIT]     = store_r;
			end else if (avs_address == drive_mode_pkg::OFS_VEL_NUM) begin
				rdata_nxt = {16'h0, vel_num_r};
			end else if (avs_address == drive_mode_pkg::OFS_VEL_DEN) begin
				rdata_nxt = {16'h0, vel_den_r};
			end else if (avs_address == drive_mode_pkg::OFS_TGT_VEL) begin
				rdata_nxt = vel_r;
			end else if (avs_address == drive_mode_pkg::OFS_ADC) begin
				rdata_nxt = {20'h0, sample};
			end else if (avs_address == drive_mode_pkg::OFS_POSITION) begin
				rdata_nxt = pos_r;
			end else begin
				rdata_nxt = 32'h0;
			end
		end
		if (wr_take) begin
			if (avs_address == drive_mode_pkg::OFS_CONTROL) begin
				special_nxt = avs_writedata[drive_mode_pkg::CTRL_SPECIAL_BIT];
			end else if (avs_address == drive_mode_pkg::OFS_CTRLWORD) begin
				ctrlword_nxt = avs_writedata[15:0];
			end else if (avs_address == drive_mode_pkg::OFS_VEL_NUM) begin
				vel_num_nxt = avs_writedata[15:0];
			end else if (avs_address == drive_mode_pkg::OFS_VEL_DEN) begin
				vel_den_nxt = avs_writedata[15:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wait_r     <= 1'b1;
			rdata_r    <= 32'h0;
			special_r  <= drive_mode_pkg::SPECIAL_RST;
			ctrlword_r <= 16'h0;
			vel_num_r  <= drive_mode_pkg::VEL_NUM_RST;
			vel_den_r  <= drive_mode_pkg::VEL_DEN_RST;
		end else begin
			wait_r     <= wait_nxt;
			rdata_r    <= rdata_nxt;
			special_r  <= special_nxt;
			ctrlword_r <= ctrlword_nxt;
			vel_num_r  <= vel_num_nxt;
			vel_den_r  <= vel_den_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode decode from the latched switch

	always_comb begin
		case (switch_r[2:0])
			3'h0, 3'h1: mode = drive_mode_pkg::MODE_STEP_DIR;
			3'h2, 3'h3: mode = drive_mode_pkg::MODE_TEST_RUN;
			3'h4, 3'h5: mode = drive_mode_pkg::MODE_ANALOG;
			default:    mode = drive_mode_pkg::MODE_JOYSTICK;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Analog speed computation

	always_comb begin
		// Bit 0 of the low value picks the slow full scale
		fs_rpm = switch_r[0] ? 32'(drive_mode_pkg::RPM_FS_SLOW)
			: 32'(drive_mode_pkg::RPM_FS_FAST);
		if (mode == drive_mode_pkg::MODE_JOYSTICK) begin
			negative = sample < 12'(drive_mode_pkg::ADC_MID);
			mag = negative ? 12'(drive_mode_pkg::ADC_MID) - sample
				: sample - 12'(drive_mode_pkg::ADC_MID);
			raw_rpm = to_rpm(dead_zone(mag), fs_rpm,
				32'(drive_mode_pkg::ADC_MID - 1));
		end else begin
			negative = direction_in;
			mag = sample;
			raw_rpm = to_rpm(dead_zone(mag), fs_rpm,
				32'(drive_mode_pkg::ADC_MAX));
		end
		// Divider by a register is wide; the sample period leaves slack
		scaled = 48'(raw_rpm) * 48'(vel_num_r);
		if (vel_den_r != 16'h0)
			speed = 32'(scaled / 48'(vel_den_r));
		else
			speed = 32'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// Switch latch, power state, setpoints and store request

	always_comb begin
		switch_nxt    = switch_r;
		latched_nxt   = 1'b1;
		// Taken once after release so a strap cannot move the mode later
		if (!latched_r)
			switch_nxt = hex_switch;
		closed_nxt = switch_r[3];

		pwr_nxt = pwr_r;
		if (special_r) begin
			pwr_nxt = enable_in ? drive_mode_pkg::PWR_ENABLED
				: drive_mode_pkg::PWR_DISABLED;
		end else begin
			pwr_nxt = ctrlword_r == drive_mode_pkg::CW_ENABLE_VAL ?
				drive_mode_pkg::PWR_ENABLED : drive_mode_pkg::PWR_DISABLED;
		end

		step_d_nxt  = step_in;
		pos_nxt     = pos_r;
		vel_nxt     = vel_r;
		velmode_nxt = special_r && (mode == drive_mode_pkg::MODE_ANALOG ||
			mode == drive_mode_pkg::MODE_JOYSTICK);
		if (special_r && latched_r) begin
			case (mode)
				drive_mode_pkg::MODE_STEP_DIR: begin
					vel_nxt = 32'h0;
					if (pwr_r == drive_mode_pkg::PWR_ENABLED && step_in &&
							!step_d_r) begin
						pos_nxt = direction_in ? pos_r - 32'h1
							: pos_r + 32'h1;
					end
				end
				drive_mode_pkg::MODE_TEST_RUN: begin
					if (pwr_r != drive_mode_pkg::PWR_ENABLED)
						vel_nxt = 32'h0;
					else if (switch_r[0])
						vel_nxt = -32'(drive_mode_pkg::RPM_TEST);
					else
						vel_nxt = 32'(drive_mode_pkg::RPM_TEST);
				end
				default: begin
					if (sample_new)
						vel_nxt = negative ? -speed : speed;
				end
			endcase
		end else if (!special_r) begin
			vel_nxt = 32'h0;
		end

		// Set wins over acknowledge
		store_nxt = store_r;
		if (store_ack)
			store_nxt = 1'b0;
		if (autosetup_ok)
			store_nxt = 1'b1;
		// Only a restart clears it
		coord_bad_nxt = coord_bad_r || autosetup_ok;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			switch_r    <= drive_mode_pkg::SWITCH_RST;
			latched_r   <= 1'b0;
			closed_r    <= 1'b0;
			pwr_r       <= drive_mode_pkg::PWR_DISABLED;
			step_d_r    <= 1'b0;
			pos_r       <= 32'h0;
			vel_r       <= 32'h0;
			velmode_r   <= 1'b0;
			store_r     <= 1'b0;
			coord_bad_r <= 1'b0;
		end else begin
			switch_r    <= switch_nxt;
			latched_r   <= latched_nxt;
			closed_r    <= closed_nxt;
			pwr_r       <= pwr_nxt;
			step_d_r    <= step_d_nxt;
			pos_r       <= pos_nxt;
			vel_r       <= vel_nxt;
			velmode_r   <= velmode_nxt;
			store_r     <= store_nxt;
			coord_bad_r <= coord_bad_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign avs_readdata     = rdata_r;
	assign avs_waitrequest  = wait_r;
	assign velocity_mode    = velmode_r;
	assign closed_loop      = closed_r;
	assign power_enabled    = pwr_r == drive_mode_pkg::PWR_ENABLED;
	assign target_velocity  = vel_r;
	assign position_cmd     = pos_r;
	assign store_req        = store_r;
	assign store_categories = {1'b0, store_r, store_r, 5'h00};

endmodule : special_drive_mode_select

// ===== dv/far_side_model.sv
// Far-side model: step pulse source and converter front end
`timescale 1ns/10ps
module far_side_model (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        adc_start,
	input  wire logic [11:0] level,
	input  wire logic        go,
	input  wire logic [7:0]  steps,
	output logic [11:0]      adc_code,
	output logic             step_in,
	output logic             busy
);
	logic [7:0] left_r;

	assign busy = left_r != 8'h00;
	// Code stands only while the start strobe is high, inverse otherwise
	assign adc_code = adc_start ? level : ~level;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			left_r <= 8'h00;
			step_in <= 1'b0;
		end else begin
			if (go && !busy)
				left_r <= steps;
			else if (busy) begin
				step_in <= ~step_in;
				if (step_in)
					left_r <= left_r - 8'h01;
			end
		end
	end
endmodule : far_side_model

// ===== dv/special_drive_checker.sv
// Port assertions for the special drive mode block
`timescale 1ns/10ps
module special_drive_checker (
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [3:0]  hex_switch,
	input wire logic        enable_in,
	input wire logic        step_in,
	input wire logic        direction_in,
	input wire logic [11:0] adc_code,
	input wire logic        autosetup_ok,
	input wire logic        store_ack,
	input wire logic        adc_start,
	input wire logic        velocity_mode,
	input wire logic        closed_loop,
	input wire logic        power_enabled,
	input wire logic [31:0] target_velocity,
	input wire logic [31:0] position_cmd,
	input wire logic        store_req,
	input wire logic [7:0]  store_categories
);
	logic        cap_r, special_r, seen_r;
	logic [3:0]  sw_r;
	logic [11:0] gap_r;

	// Shadow of the latched switch and the activation bit
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cap_r <= 1'b1;
			special_r <= 1'b1;
			seen_r <= 1'b0;
			gap_r <= 12'h000;
		end else begin
			cap_r <= 1'b0;
			if (cap_r)
				sw_r <= hex_switch;
			if (avs_write && !avs_waitrequest &&
					avs_address == drive_mode_pkg::OFS_CONTROL)
				special_r <= avs_writedata[0];
			gap_r <= adc_start ? 12'h000 : gap_r + 12'h001;
			seen_r <= seen_r | adc_start;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence test_mode;
		!cap_r && special_r && sw_r[2:1] == 2'b01;
	endsequence
	sequence en_held;
		enable_in [*4];
	endsequence

	store_set_a: assert property (autosetup_ok |=> store_req)
		else $error("store request missing after auto setup");
	store_keep_a: assert property (store_req && !store_ack |=> store_req)
		else $error("store request dropped early");
	store_done_a: assert property (store_ack && !autosetup_ok |=> !store_req)
		else $error("store request not cleared");
	store_cat_a: assert property (store_categories == (store_req ? 8'h60 : 8'h00))
		else $error("store categories wrong");
	power_follow_a: assert property (special_r && $past(special_r) &&
		!$past(sys_rst) |-> power_enabled == $past(enable_in))
		else $error("power state not following enable");
	loop_mode_a: assert property (!cap_r |=> closed_loop == sw_r[3])
		else $error("control loop does not match switch");
	vel_mode_a: assert property (!cap_r |=>
		velocity_mode == (sw_r[2] && $past(special_r)))
		else $error("velocity mode wrong");
	step_still_a: assert property (!cap_r && sw_r[2:1] == 2'b00 |=>
		target_velocity == 32'h0)
		else $error("speed set in step mode");
	test_speed_a: assert property (test_mode ##0 en_held |->
		target_velocity == (sw_r[0] ? 32'hffff_ffe2 : 32'h0000_001e))
		else $error("test run speed wrong");
	sample_rate_a: assert property (adc_start && seen_r |->
		gap_r == 12'(drive_mode_pkg::SAMPLE_CYC - 1))
		else $error("sample strobe period wrong");
	sample_due_a: assert property (seen_r |->
		gap_r < 12'(drive_mode_pkg::SAMPLE_CYC))
		else $error("sample strobe overdue");
endmodule : special_drive_checker

bind special_drive_mode_select special_drive_checker u_checker (.*);

// ===== dv/special_drive_mode_select_test.sv
// Self-checking bench for the special drive mode block
`timescale 1ns/10ps
module special_drive_mode_select_test;
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, target_velocity, position_cmd, rd;
	logic        avs_waitrequest, adc_start, velocity_mode, closed_loop;
	logic        power_enabled, store_req, step_in, busy;
	logic [7:0]  store_categories;
	logic [7:0]  steps = 8'h00;
	logic [3:0]  hex_switch = 4'h1;
	logic [11:0] adc_code;
	logic [11:0] level = 12'h000;
	logic        enable_in = 1'b0;
	logic        direction_in = 1'b0;
	logic        autosetup_ok = 1'b0;
	logic        store_ack = 1'b0;
	logic        go = 1'b0;
	integer      seed = 32'hfb08;
	int          n_errors = 0;
	int          total_checks = 0;

	always #25 core_clk = ~core_clk;

	special_drive_mode_select dut (.*);
	far_side_model u_far (.*);

	////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [4:0] a,
			input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		// Only the watchdog ends a wait for the answer
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge core_clk);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic restart(input logic [3:0] sw);
		@(posedge core_clk);
		hex_switch <= sw;
		sys_rst <= 1'b1;
		cyc(2);
		sys_rst <= 1'b0;
		cyc(1);
		// Later switch moves must not be picked up
		hex_switch <= 4'($random(seed));
		cyc(2);
	endtask : restart

	task automatic move(input logic [7:0] n);
		int i;
		@(posedge core_clk);
		steps <= n;
		go <= 1'b1;
		cyc(1);
		go <= 1'b0;
		cyc(1);
		for (i = 0; i < 600 && busy !== 1'b0; i++) cyc(1);
		cyc(3);
	endtask : move

	task automatic sample;
		int i;
		// Let a level set just before reach the converter first
		cyc(1);
		for (i = 0; i < 2100 && adc_start !== 1'b1; i++) cyc(1);
		if (i == 2100) n_errors++;
		cyc(4);
	endtask : sample

	function automatic logic [31:0] exp_speed(input logic [3:0] sw,
			input int c, input logic dir, input int num, input int den);
		int fs, d, v;
		fs = sw[0] ? drive_mode_pkg::RPM_FS_SLOW : drive_mode_pkg::RPM_FS_FAST;
		d = sw[1] ? c - drive_mode_pkg::ADC_MID : c;
		v = d < 0 ? -d : d;
		if (v <= drive_mode_pkg::DEAD_CODES)
			v = 0;
		else
			v = v * fs / (sw[1] ? drive_mode_pkg::ADC_MID - 1
				: drive_mode_pkg::ADC_MAX);
		if (sw[1] ? d < 0 : dir)
			v = -v;
		return 32'(v * num / den);
	endfunction : exp_speed

	task automatic results;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////
	initial begin
		int k, n;
		logic [3:0] sw;
		for (int s = 0; s < 16; s++) begin
			sw = 4'(s);
			restart(sw);
			bus(1'b0, drive_mode_pkg::OFS_STATUS, 32'h0);
			chk(32'(rd[3:0]), 32'(sw));
			chk(32'(closed_loop), 32'(sw[3]));
			chk(32'(velocity_mode), 32'(sw[2]));
			direction_in <= 1'($random(seed));
			if (sw[2:1] == 2'b00) begin
				move(8'h03);
				chk(position_cmd, 32'h0);
			end
			enable_in <= 1'b1;
			cyc(3);
			chk(32'(power_enabled), 32'h1);
			case (sw[2:1])
			2'b00: begin
				n = 1 + ($random(seed) & 15);
				move(8'(n));
				chk(position_cmd, direction_in ? 32'(-n) : 32'(n));
				bus(1'b0, drive_mode_pkg::OFS_POSITION, 32'h0);
				chk(rd, direction_in ? 32'(-n) : 32'(n));
			end
			2'b01: chk(target_velocity, sw[0] ? 32'hffff_ffe2 : 32'h1e);
			default: for (k = 0; k < 3; k++) begin
				// Random level, then the edge of the dead zone
				level <= k == 0 ? 12'($random(seed)) : 12'((sw[1] ?
					drive_mode_pkg::ADC_MID : 0) + 7 + k);
				sample();
				chk(target_velocity, exp_speed(sw, level, direction_in, 1, 1));
			end
			endcase
			enable_in <= 1'b0;
			bus(1'b1, drive_mode_pkg::OFS_CTRLWORD, 32'h000f);
			cyc(3);
			chk(32'(power_enabled), 32'h0);
			if (sw[2:1] == 2'b01)
				chk(target_velocity, 32'h0);
		end
		restart(4'h4);
		enable_in <= 1'b1;
		direction_in <= 1'b0;
		bus(1'b0, drive_mode_pkg::OFS_VEL_NUM, 32'h0);
		chk(rd, 32'h1);
		bus(1'b1, drive_mode_pkg::OFS_VEL_NUM, 32'h3);
		bus(1'b1, drive_mode_pkg::OFS_VEL_DEN, 32'h2);
		level <= 12'hfff;
		sample();
		chk(target_velocity, exp_speed(4'h4, 4095, 1'b0, 3, 2));
		bus(1'b0, drive_mode_pkg::OFS_TGT_VEL, 32'h0);
		chk(rd, exp_speed(4'h4, 4095, 1'b0, 3, 2));
		bus(1'b0, drive_mode_pkg::OFS_ADC, 32'h0);
		chk(rd, 32'hfff);
		// A zero divisor must park the motor
		bus(1'b1, drive_mode_pkg::OFS_VEL_DEN, 32'h0);
		sample();
		chk(target_velocity, 32'h0);
		bus(1'b0, drive_mode_pkg::OFS_CONTROL, 32'h0);
		chk(rd, 32'h1);
		bus(1'b1, drive_mode_pkg::OFS_CONTROL, 32'h0);
		bus(1'b1, drive_mode_pkg::OFS_CTRLWORD, 32'h000f);
		enable_in <= 1'b0;
		cyc(3);
		chk(32'(velocity_mode), 32'h0);
		chk(32'(power_enabled), 32'h1);
		@(posedge core_clk);
		autosetup_ok <= 1'b1;
		cyc(1);
		autosetup_ok <= 1'b0;
		cyc(1);
		chk({24'h0, store_categories}, 32'h60);
		bus(1'b0, drive_mode_pkg::OFS_STATUS, 32'h0);
		chk(32'(rd[8:7]), 32'h3);
		// Set and acknowledge together: the set must win
		autosetup_ok <= 1'b1;
		store_ack <= 1'b1;
		cyc(1);
		autosetup_ok <= 1'b0;
		store_ack <= 1'b0;
		cyc(2);
		chk(32'(store_req), 32'h1);
		store_ack <= 1'b1;
		cyc(1);
		store_ack <= 1'b0;
		cyc(2);
		chk(32'(store_req), 32'h0);
		restart(4'h1);
		bus(1'b0, drive_mode_pkg::OFS_STATUS, 32'h0);
		chk(32'(rd[7]), 32'h0);
		results();
	end

	initial begin
		cyc(95000);
		n_errors++;
		results();
	end
endmodule : special_drive_mode_select_test

// ===== inc/drive_mode_pkg.sv
// Constants, register map and types for the special drive mode block
package drive_mode_pkg;

	// Register byte offsets
	localparam logic [4:0] OFS_CONTROL   = 5'h00;
	localparam logic [4:0] OFS_CTRLWORD  = 5'h04;
	localparam logic [4:0] OFS_STATUS    = 5'h08;
	localparam logic [4:0] OFS_VEL_NUM   = 5'h0c;
	localparam logic [4:0] OFS_VEL_DEN   = 5'h10;
	localparam logic [4:0] OFS_TGT_VEL   = 5'h14;
	localparam logic [4:0] OFS_ADC       = 5'h18;
	localparam logic [4:0] OFS_POSITION  = 5'h1c;

	// Field positions
	localparam int CTRL_SPECIAL_BIT   = 0;
	localparam int STAT_SWITCH_LSB    = 0;
	localparam int STAT_CLOSED_BIT    = 4;
	localparam int STAT_ENABLED_BIT   = 5;
	localparam int STAT_SPECIAL_BIT   = 6;
	localparam int STAT_COORD_BAD_BIT = 7;
	localparam int STAT_STORE_BIT     = 8;
	localparam int STORE_CAT_DRIVE    = 5;
	localparam int STORE_CAT_TUNING   = 6;

	// Reset values and controlword enable value
	localparam logic        SPECIAL_RST   = 1'b1;
	localparam logic [3:0]  SWITCH_RST    = 4'h1;
	localparam logic [15:0] VEL_NUM_RST   = 16'h0001;
	localparam logic [15:0] VEL_DEN_RST   = 16'h0001;
	localparam logic [15:0] CW_ENABLE_VAL = 16'h000f;

	// Speeds in rpm
	localparam int RPM_TEST      = 30;
	localparam int RPM_FS_FAST   = 1000;
	localparam int RPM_FS_SLOW   = 100;

	// Analog converter: 12-bit code over a 10 V span
	localparam int ADC_BITS      = 12;
	localparam int ADC_FS_MV     = 10000;
	localparam int DEAD_MV       = 20;
	localparam int ADC_MAX       = (1 << ADC_BITS) - 1;
	localparam int ADC_MID       = 1 << (ADC_BITS - 1);
	localparam int DEAD_CODES    = (DEAD_MV * (ADC_MAX + 1)) / ADC_FS_MV;

	// Sampling period
	localparam int CLK_HZ        = 20_000_000;
	localparam int SAMPLE_US     = 100;
	localparam int SAMPLE_CYC    = (SAMPLE_US * (CLK_HZ / 1_000_000));

	typedef enum logic [1:0] {
		MODE_STEP_DIR,
		MODE_TEST_RUN,
		MODE_ANALOG,
		MODE_JOYSTICK
	} drive_mode_t;

	typedef enum logic {
		PWR_DISABLED,
		PWR_ENABLED
	} power_state_t;

endpackage : drive_mode_pkg
